// ===== design/lsam_pkg.sv
// constants and types shared by the lin state and address match block
package lsam_pkg;
  // register indexes; byte address is four times the index
  localparam logic [11:0] IDX_LIN_CTRL  = 12'hF43;
  localparam logic [11:0] IDX_ADDR_CMP  = 12'hF45;
  localparam logic [11:0] IDX_CFG       = 12'hF50;
  localparam logic [11:0] IDX_IRQ_STAT  = 12'hF51;
  localparam logic [11:0] IDX_IRQ_MASK  = 12'hF52;
  localparam logic [11:0] IDX_BREAK_CMD = 12'hF53;

  // lin control fields
  localparam int unsigned CTL_MST_BIT   = 7;
  localparam int unsigned CTL_SLV_BIT   = 6;
  localparam int unsigned CTL_ABEN_BIT  = 5;
  localparam int unsigned CTL_AUTOBAUD_IRQ_ENABLE_BIT = 4;
  localparam int unsigned CTL_STATE_LSB = 2;
  localparam int unsigned CTL_BRK_LSB   = 0;

  // configuration fields
  localparam int unsigned CFG_MULTINODE_ENABLE_BIT  = 0;
  localparam int unsigned CFG_PEN_BIT   = 1;
  localparam int unsigned CFG_MODE_LSB  = 2;
  localparam int unsigned CFG_CMP_BIT   = 3;
  localparam int unsigned CFG_MST_RO    = 4;
  localparam int unsigned CFG_SLV_RO    = 5;
  localparam int unsigned CFG_MATCH_RO  = 6;
  localparam int unsigned CFG_AVAIL_RO  = 7;

  // interrupt status and mask layout
  localparam int unsigned IRQ_W         = 4;
  localparam int unsigned IRQ_RX_BIT    = 0;
  localparam int unsigned IRQ_ABD_BIT   = 1;
  localparam int unsigned IRQ_BRK_BIT   = 2;
  localparam int unsigned IRQ_HWST_BIT  = 3;

  // break command register
  localparam int unsigned BRK_GO_BIT    = 0;

  // values after reset
  localparam logic [7:0]       LIN_CTRL_RST = 8'h00;
  localparam logic [7:0]       ADDR_CMP_RST = 8'h00;
  localparam logic [3:0]       CFG_RST      = 4'h0;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;

  // break length is this many bit times plus the select value
  localparam int unsigned BRK_CNT_W     = 5;
  localparam logic [4:0]  BRK_BASE_BITS = 5'h0D;

  // ahb-lite
  localparam int unsigned HTRANS_ACT_BIT = 1;
  localparam logic [1:0]  HRESP_OKAY     = 2'h0;

  typedef enum logic [1:0] {
    LSAM_SLEEP,
    LSAM_WAIT_BREAK,
    LSAM_AUTOBAUD,
    LSAM_ACTIVE
  } lsam_state_type;
endpackage

// ===== design/lsam_break_timer.sv
// master break generator counting bit-time enable pulses
`timescale 1ns/10ps
`default_nettype none
module lsam_break_timer (
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        nrst,
  // control
  input  wire logic                        start,
  input  wire logic                        bit_tick,
  input  wire logic [1:0]                  length_sel,
  // status
  output logic                             break_low,
  output logic                             done
);
  import lsam_pkg::*;

  logic [BRK_CNT_W-1:0] count;
  logic [BRK_CNT_W-1:0] target;
  logic [BRK_CNT_W-1:0] next_target;
  logic                 last_bit;

  // 13 + select gives 13, 14, 15 or 16 bit times
  assign next_target = BRK_BASE_BITS + {3'h0, length_sel};
  assign last_bit    = break_low && bit_tick && (count == target - 5'h01);

  // first bit time may be partial: start is not aligned to the tick
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      break_low <= 1'b0;
      done      <= 1'b0;
      count     <= '0;
      target    <= BRK_BASE_BITS;
    end else begin
      done <= last_bit;
      if (start && !break_low) begin
        break_low <= 1'b1;
        count     <= '0;
        target    <= next_target;
      end else if (last_bit) begin
        break_low <= 1'b0;
      end else if (break_low && bit_tick) begin
        count <= count + 5'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ===== design/lsam_top.sv
// lin state machine, break length select and multinode address filter
`timescale 1ns/10ps
`default_nettype none
module lsam_top (
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        nrst,
  // ahb-lite slave
  input  wire logic                        hsel,
  input  wire logic [31:0]                 haddr,
  input  wire logic [1:0]                  htrans,
  input  wire logic                        hwrite,
  input  wire logic [2:0]                  hsize,
  input  wire logic [31:0]                 hwdata,
  input  wire logic                        hready,
  output logic [31:0]                      hrdata,
  output logic                             hreadyout,
  output logic [1:0]                       hresp,
  // from the rest of the unit
  input  wire logic                        bit_tick,
  input  wire logic                        break_detected,
  input  wire logic                        autobaud_char_done,
  input  wire logic                        rx_byte_valid,
  input  wire logic                        rx_byte_is_address,
  input  wire logic [7:0]                  rx_byte_data,
  input  wire logic                        rx_byte_taken,
  // to the rest of the unit
  output logic [1:0]                       bus_state_field,
  output logic                             master_mode_active,
  output logic                             slave_mode_active,
  output logic                             autobaud_active,
  output logic                             tx_break_low,
  output logic                             rx_byte_available,
  output logic                             rx_irq,
  output logic                             autobaud_done_flag,
  output logic                             irq
);
  import lsam_pkg::*;

  // bus data phase
  logic        dp_valid;
  logic        dp_write;
  logic        dp_map;
  logic [11:0] dp_idx;
  logic        rd_wait;
  logic        take;
  logic        wr_en;
  logic        rd_stall;

  // registers
  logic                 master_role_select;
  logic                 slave_role_select;
  logic                 autobaud_enable;
  logic                 autobaud_irq_enable;
  logic [1:0]           break_duration_select;
  lsam_state_type       state;
  lsam_state_type       next_state;
  logic [7:0]           node_address_compare;
  logic                 multinode_enable;
  logic                 parity_enable;
  logic [1:0]           multinode_mode_field;
  logic [IRQ_W-1:0]     irq_stat;
  logic [IRQ_W-1:0]     irq_mask;
  logic [IRQ_W-1:0]     irq_events;
  logic [IRQ_W-1:0]     irq_clear;
  logic                 addr_matched;
  logic                 next_rx_byte_available;
  logic                 next_rx_irq;
  logic [IRQ_W-1:0]     next_irq_stat;

  // decode and events
  logic        wr_ctrl;
  logic        wr_addr;
  logic        wr_cfg;
  logic        wr_stat;
  logic        wr_mask;
  logic        wr_brk;
  logic        sel_ctrl;
  logic        sel_addr;
  logic        sel_cfg;
  logic        sel_stat;
  logic        sel_mask;
  logic [7:0]  ctrl_value;
  logic [7:0]  cfg_value;
  logic [31:0] rd_data;
  logic        st_sleep;
  logic        st_wait;
  logic        st_autobaud;
  logic        st_active;
  logic        hw_break_step;
  logic        hw_baud_step;
  logic        hw_step;
  logic        abd_event;
  logic        cmp_on;
  logic        addr_hit;
  logic        deliver;
  logic        brk_start;
  logic        brk_done;

  // ---------------- ahb-lite slave ----------------
  assign take      = hsel && htrans[HTRANS_ACT_BIT] && hready;
  assign rd_stall  = dp_valid && !dp_write && rd_wait;
  // one wait state on reads so a write just before is seen
  assign hreadyout = !rd_stall;
  assign hresp     = HRESP_OKAY;
  assign wr_en     = dp_valid && dp_write && dp_map;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_map   <= 1'b0;
      dp_idx   <= '0;
      rd_wait  <= 1'b0;
    end else if (take) begin
      dp_valid <= 1'b1;
      dp_write <= hwrite;
      dp_map   <= (haddr[31:14] == 18'h00000);
      dp_idx   <= haddr[13:2];
      rd_wait  <= !hwrite;
    end else if (rd_stall) begin
      rd_wait  <= 1'b0;
    end else begin
      dp_valid <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hrdata <= 32'h00000000;
    end else if (rd_stall) begin
      hrdata <= rd_data;
    end
  end

  assign wr_ctrl = wr_en && (dp_idx == IDX_LIN_CTRL);
  assign wr_addr = wr_en && (dp_idx == IDX_ADDR_CMP);
  assign wr_cfg  = wr_en && (dp_idx == IDX_CFG);
  assign wr_stat = wr_en && (dp_idx == IDX_IRQ_STAT);
  assign wr_mask = wr_en && (dp_idx == IDX_IRQ_MASK);
  assign wr_brk  = wr_en && (dp_idx == IDX_BREAK_CMD);

  assign sel_ctrl = dp_map && (dp_idx == IDX_LIN_CTRL);
  assign sel_addr = dp_map && (dp_idx == IDX_ADDR_CMP);
  assign sel_cfg  = dp_map && (dp_idx == IDX_CFG);
  assign sel_stat = dp_map && (dp_idx == IDX_IRQ_STAT);
  assign sel_mask = dp_map && (dp_idx == IDX_IRQ_MASK);

  // state field reads back the live state, hardware moves included
  assign ctrl_value = {master_role_select, slave_role_select, autobaud_enable,
                       autobaud_irq_enable, state, break_duration_select};
  assign cfg_value  = {rx_byte_available, addr_matched, slave_mode_active,
                       master_mode_active, multinode_mode_field,
                       parity_enable, multinode_enable};

  // unmapped and write-only addresses read as zero
  assign rd_data = ({32{sel_ctrl}} & {24'h000000, ctrl_value})
                 | ({32{sel_addr}} & {24'h000000, node_address_compare})
                 | ({32{sel_cfg}}  & {24'h000000, cfg_value})
                 | ({32{sel_stat}} & {28'h0000000, irq_stat})
                 | ({32{sel_mask}} & {28'h0000000, irq_mask});

  // ---------------- control and configuration ----------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      master_role_select    <= LIN_CTRL_RST[CTL_MST_BIT];
      slave_role_select     <= LIN_CTRL_RST[CTL_SLV_BIT];
      autobaud_enable       <= LIN_CTRL_RST[CTL_ABEN_BIT];
      autobaud_irq_enable   <= LIN_CTRL_RST[CTL_AUTOBAUD_IRQ_ENABLE_BIT];
      break_duration_select <= LIN_CTRL_RST[CTL_BRK_LSB +: 2];
    end else if (wr_ctrl) begin
      master_role_select    <= hwdata[CTL_MST_BIT];
      slave_role_select     <= hwdata[CTL_SLV_BIT];
      autobaud_enable       <= hwdata[CTL_ABEN_BIT];
      autobaud_irq_enable   <= hwdata[CTL_AUTOBAUD_IRQ_ENABLE_BIT];
      break_duration_select <= hwdata[CTL_BRK_LSB +: 2];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      node_address_compare <= ADDR_CMP_RST;
    end else if (wr_addr) begin
      node_address_compare <= hwdata[7:0];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      multinode_enable     <= CFG_RST[CFG_MULTINODE_ENABLE_BIT];
      parity_enable        <= CFG_RST[CFG_PEN_BIT];
      multinode_mode_field <= CFG_RST[CFG_MODE_LSB +: 2];
    end else if (wr_cfg) begin
      multinode_enable     <= hwdata[CFG_MULTINODE_ENABLE_BIT];
      parity_enable        <= hwdata[CFG_PEN_BIT];
      multinode_mode_field <= hwdata[CFG_MODE_LSB +: 2];
    end
  end

  // both role bits set selects neither role
  assign master_mode_active = master_role_select && !multinode_enable
                           && !parity_enable && !slave_role_select;
  assign slave_mode_active  = slave_role_select && !multinode_enable
                           && !parity_enable && !master_role_select;

  // ---------------- lin state machine ----------------
  assign st_sleep    = (state == LSAM_SLEEP);
  assign st_active   = (state == LSAM_ACTIVE);
  // wait and autobaud only act for a slave
  assign st_wait     = slave_mode_active && (state == LSAM_WAIT_BREAK);
  assign st_autobaud = slave_mode_active && (state == LSAM_AUTOBAUD);
  assign autobaud_active = st_autobaud && autobaud_enable;
  assign bus_state_field = state;

  // master mode has no hardware moves at all
  assign hw_break_step = st_wait && break_detected;
  assign hw_baud_step  = st_autobaud && autobaud_char_done;
  assign hw_step       = (hw_break_step || hw_baud_step) && !wr_ctrl;

  always_comb begin
    next_state = state;
    unique case (state)
      LSAM_WAIT_BREAK: begin
        // without autobaud the break leads straight to active
        if (hw_break_step) begin
          next_state = autobaud_enable ? LSAM_AUTOBAUD : LSAM_ACTIVE;
        end
      end
      LSAM_AUTOBAUD: begin
        if (hw_baud_step) begin
          next_state = LSAM_ACTIVE;
        end
      end
      LSAM_SLEEP,
      LSAM_ACTIVE: begin
        next_state = state;
      end
    endcase
    // software forces any state at any time and wins over hardware
    if (wr_ctrl) begin
      next_state = lsam_state_type'(hwdata[CTL_STATE_LSB +: 2]);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= LSAM_SLEEP;
    end else begin
      state <= next_state;
    end
  end

  // ---------------- master break ----------------
  assign brk_start = wr_brk && hwdata[BRK_GO_BIT] && master_mode_active && st_active;

  lsam_break_timer u_break (
    .clk        (clk),
    .nrst       (nrst),
    .start      (brk_start),
    .bit_tick   (bit_tick),
    .length_sel (break_duration_select),
    .break_low  (tx_break_low),
    .done       (brk_done)
  );

  // ---------------- address filter and receive events ----------------
  assign cmp_on   = multinode_mode_field[1];
  assign addr_hit = (rx_byte_data == node_address_compare);
  // matching address byte itself is delivered too
  assign deliver  = rx_byte_valid && (!cmp_on
                  || (rx_byte_is_address ? addr_hit : addr_matched));
  assign abd_event = hw_baud_step && autobaud_irq_enable;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      addr_matched <= 1'b0;
    end else if (rx_byte_valid && rx_byte_is_address && cmp_on) begin
      addr_matched <= addr_hit;
    end
  end

  // set beats the take pulse so no byte is lost
  assign next_rx_byte_available = deliver || (rx_byte_available && !rx_byte_taken);
  assign next_rx_irq            = deliver || abd_event;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_byte_available <= 1'b0;
      rx_irq            <= 1'b0;
    end else begin
      rx_byte_available <= next_rx_byte_available;
      rx_irq            <= next_rx_irq;
    end
  end

  // ---------------- interrupt status and mask ----------------
  assign irq_events[IRQ_RX_BIT]   = deliver;
  assign irq_events[IRQ_ABD_BIT]  = abd_event;
  assign irq_events[IRQ_BRK_BIT]  = brk_done;
  assign irq_events[IRQ_HWST_BIT] = hw_step;
  assign irq_clear = wr_stat ? hwdata[IRQ_W-1:0] : '0;
  // an event beats a clear written in the same cycle
  assign next_irq_stat = (irq_stat & ~irq_clear) | irq_events;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_stat <= '0;
      irq_mask <= IRQ_MASK_RST;
    end else begin
      irq_stat <= next_irq_stat;
      if (wr_mask) begin
        irq_mask <= hwdata[IRQ_W-1:0];
      end
    end
  end

  assign autobaud_done_flag = irq_stat[IRQ_ABD_BIT];
  assign irq = |(irq_stat & irq_mask);
endmodule
`default_nettype wire

// ===== testbench/lsam_top_sva.sv
// assertions on the lin state and address match top ports
`timescale 1ns/10ps
`default_nettype none
module lsam_top_sva
  import lsam_pkg::*;
(
  // clock and reset
  input wire logic       clk,
  input wire logic       nrst,
  // bus
  input wire logic       hsel,
  input wire logic [1:0] htrans,
  input wire logic       hwrite,
  input wire logic       hready,
  input wire logic       hreadyout,
  input wire logic [1:0] hresp,
  // unit side
  input wire logic       bit_tick,
  input wire logic       break_detected,
  input wire logic       autobaud_char_done,
  input wire logic       rx_byte_valid,
  input wire logic [1:0] bus_state_field,
  input wire logic       master_mode_active,
  input wire logic       slave_mode_active,
  input wire logic       tx_break_low,
  input wire logic       rx_byte_available,
  input wire logic       rx_irq,
  input wire logic       autobaud_done_flag
);
  logic       taken;
  logic       wr_pend;
  logic [4:0] ticks;
  assign taken = hsel & htrans[HTRANS_ACT_BIT] & hready;
  // a write lands at the edge ending its data phase, so it excuses state moves
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_pend <= 1'b0;
      ticks   <= 5'h00;
    end else begin
      wr_pend <= taken & hwrite;
      ticks   <= tx_break_low ? ticks + {4'h0, bit_tick} : 5'h00;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  a_bus_okay: assert property (hresp == HRESP_OKAY)
    else $error("response not okay");
  a_read_wait: assert property (taken && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_roles_excl: assert property (!(master_mode_active && slave_mode_active))
    else $error("both roles active");
  a_sleep_hold: assert property (bus_state_field == 2'h0 && !wr_pend |=> bus_state_field == 2'h0)
    else $error("hardware left sleep");
  a_break_step: assert property (slave_mode_active && bus_state_field == 2'h1 && break_detected
    && !wr_pend |=> bus_state_field inside {2'h2, 2'h3}) else $error("no step after break");
  a_autobaud_step: assert property (slave_mode_active && bus_state_field == 2'h2
    && autobaud_char_done && !wr_pend |=> bus_state_field == 2'h3) else $error("no step");
  a_master_hold: assert property ($changed(bus_state_field) && $past(master_mode_active)
    |-> $past(wr_pend)) else $error("master state moved by hardware");
  a_break_len: assert property ($fell(tx_break_low) |-> ticks inside {[5'h0D:5'h10]})
    else $error("break length out of range");
  a_rx_cause: assert property (rx_irq |-> $past(rx_byte_valid) || $past(autobaud_char_done))
    else $error("receive irq without cause");
  a_avail_rise: assert property ($rose(rx_byte_available) |-> $past(rx_byte_valid))
    else $error("available without byte");
  a_abd_flag: assert property ($rose(autobaud_done_flag) |-> $past(autobaud_char_done)
    && $past(bus_state_field) == 2'h2) else $error("autobaud flag without character");
endmodule

bind lsam_top lsam_top_sva u_sva (
  .clk(clk), .nrst(nrst), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .bit_tick(bit_tick),
  .break_detected(break_detected), .autobaud_char_done(autobaud_char_done),
  .rx_byte_valid(rx_byte_valid), .bus_state_field(bus_state_field),
  .master_mode_active(master_mode_active), .slave_mode_active(slave_mode_active),
  .tx_break_low(tx_break_low), .rx_byte_available(rx_byte_available),
  .rx_irq(rx_irq), .autobaud_done_flag(autobaud_done_flag)
);
`default_nettype wire

// ===== testbench/lsam_lin_node.sv
// far side bus node and receive path stand-in driving the unit-side pulses
`timescale 1ns/10ps
`default_nettype none
module lsam_lin_node (
  // clock
  input  wire logic  clk,
  // pulses toward the block
  output logic       bit_tick,
  output logic       break_detected,
  output logic       autobaud_char_done,
  output logic       rx_byte_valid,
  output logic       rx_byte_is_address,
  output logic [7:0] rx_byte_data
);
  logic [1:0] div;
  initial begin
    div = 2'h0;
    bit_tick = 1'b0;
    break_detected = 1'b0;
    autobaud_char_done = 1'b0;
    rx_byte_valid = 1'b0;
    rx_byte_is_address = 1'b0;
    rx_byte_data = 8'h00;
  end
  // four clocks a bit keeps breaks short in simulation
  always @(posedge clk) begin
    div <= div + 2'h1;
    bit_tick <= (div == 2'h3);
  end
  task automatic pulse(input logic abd);
    if (abd) autobaud_char_done <= 1'b1;
    else break_detected <= 1'b1;
    @(posedge clk);
    autobaud_char_done <= 1'b0;
    break_detected <= 1'b0;
  endtask
  // byte lines carry junk once released so stale data never matches
  task automatic send(input logic adr, input logic [7:0] d, input int gap);
    repeat (gap) @(posedge clk);
    rx_byte_valid <= 1'b1;
    rx_byte_is_address <= adr;
    rx_byte_data <= d;
    @(posedge clk);
    rx_byte_valid <= 1'b0;
    rx_byte_is_address <= ~adr;
    rx_byte_data <= ~d;
  endtask
endmodule
`default_nettype wire

// ===== testbench/lsam_top_test.sv
// self-checking bench for the lin state and address match block
`timescale 1ns/10ps
`default_nettype none
module lsam_top_test;
  import lsam_pkg::*;
  logic        clk, nrst, hsel, hwrite, hreadyout, rx_byte_taken, bit_tick;
  logic        break_detected, autobaud_char_done, rx_byte_valid, rx_byte_is_address;
  logic        master_mode_active, slave_mode_active, autobaud_active, tx_break_low;
  logic        rx_byte_available, rx_irq, autobaud_done_flag, irq;
  logic [1:0]  htrans, hresp, bus_state_field;
  logic [2:0]  hsize;
  logic [7:0]  rx_byte_data;
  logic [31:0] haddr, hwdata, hrdata;
  int          failures, checks, cyc, rx_cnt;

  lsam_top u_lsam_top (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .bit_tick(bit_tick), .break_detected(break_detected),
    .autobaud_char_done(autobaud_char_done), .rx_byte_valid(rx_byte_valid),
    .rx_byte_is_address(rx_byte_is_address), .rx_byte_data(rx_byte_data),
    .rx_byte_taken(rx_byte_taken), .bus_state_field(bus_state_field),
    .master_mode_active(master_mode_active), .slave_mode_active(slave_mode_active),
    .autobaud_active(autobaud_active), .tx_break_low(tx_break_low),
    .rx_byte_available(rx_byte_available), .rx_irq(rx_irq),
    .autobaud_done_flag(autobaud_done_flag), .irq(irq));
  lsam_lin_node u_lsam_lin_node (.clk(clk), .bit_tick(bit_tick),
    .break_detected(break_detected), .autobaud_char_done(autobaud_char_done),
    .rx_byte_valid(rx_byte_valid), .rx_byte_is_address(rx_byte_is_address),
    .rx_byte_data(rx_byte_data));

  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (rx_irq === 1'b1) rx_cnt <= rx_cnt + 1;
    if (cyc == 20000) begin
      failures = failures + 1;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %0t %s got %h", $time, m, got);
    end
  endtask
  // no wait count assumed: each phase holds until hready is seen high
  task automatic bus(input logic w, input logic [11:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {18'h0, idx, 2'h0};
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [11:0] idx, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, idx, d, x);
  endtask
  task automatic chkrd(input logic [11:0] idx, input logic [31:0] exp, input string m);
    logic [31:0] d;
    bus(1'b0, idx, 32'h0, d);
    chk(d, exp, m);
  endtask

  task automatic t_regs();
    chkrd(IDX_LIN_CTRL, 32'h0, "control reset");
    chkrd(IDX_ADDR_CMP, 32'h0, "address reset");
    wr(IDX_ADDR_CMP, 32'hFFFFFFA5);
    chkrd(IDX_ADDR_CMP, 32'hA5, "address read back");
    wr(12'h0FF, 32'h5A);
    chkrd(12'h0FF, 32'h0, "unmapped read");
    $display("test regs done");
  endtask
  task automatic t_slave();
    int n;
    wr(IDX_IRQ_MASK, 32'h2);
    for (int s = 0; s < 4; s++) begin
      wr(IDX_LIN_CTRL, 32'h40 | (s << 2));
      chkrd(IDX_LIN_CTRL, 32'h40 | (s << 2), "state write");
    end
    wr(IDX_LIN_CTRL, 32'h74);
    @(posedge clk);
    chk(32'(slave_mode_active), 32'h1, "slave role");
    n = rx_cnt;
    u_lsam_lin_node.pulse(1'b0);
    chkrd(IDX_LIN_CTRL, 32'h78, "to autobaud");
    chk(32'(autobaud_active), 32'h1, "autobaud active");
    u_lsam_lin_node.pulse(1'b1);
    repeat (3) @(posedge clk);
    chk(rx_cnt - n, 32'h1, "autobaud receive irq");
    chk(32'(autobaud_done_flag & irq), 32'h1, "autobaud flag");
    chkrd(IDX_LIN_CTRL, 32'h7C, "to active");
    wr(IDX_IRQ_STAT, 32'h2);
    @(posedge clk);
    chk(32'(autobaud_done_flag | irq), 32'h0, "flag cleared");
    wr(IDX_LIN_CTRL, 32'h70);
    u_lsam_lin_node.pulse(1'b0);
    chkrd(IDX_LIN_CTRL, 32'h70, "sleep holds");
    $display("test slave done");
  endtask
  task automatic t_master();
    int   n;
    logic seen;
    wr(IDX_LIN_CTRL, 32'h84);
    u_lsam_lin_node.pulse(1'b0);
    chkrd(IDX_LIN_CTRL, 32'h84, "no wait step as master");
    for (int s = 0; s < 4; s++) begin
      wr(IDX_LIN_CTRL, 32'h8C | s);
      @(posedge clk);
      chk(32'(master_mode_active), 32'h1, "master role");
      u_lsam_lin_node.pulse(1'b0);
      wr(IDX_BREAK_CMD, 32'h1);
      n = 0;
      seen = 1'b0;
      for (int i = 0; i < 200; i++) begin
        @(posedge clk);
        if (tx_break_low === 1'b1) begin
          seen = 1'b1;
          n += int'(bit_tick);
        end else if (seen) break;
      end
      chk(n, 13 + s, "break length");
      chkrd(IDX_LIN_CTRL, 32'h8C | s, "master stays active");
    end
    wr(IDX_CFG, 32'h2);
    @(posedge clk);
    chk(32'(master_mode_active), 32'h0, "parity blocks master");
    wr(IDX_CFG, 32'h0);
    chkrd(IDX_CFG, 32'h10, "master role readback");
    chkrd(IDX_IRQ_STAT, 32'hC, "break and move flags");
    $display("test master done");
  endtask
  task automatic t_filter();
    int n;
    wr(IDX_CFG, 32'h8);
    wr(IDX_ADDR_CMP, 32'h5A);
    n = rx_cnt;
    u_lsam_lin_node.send(1'b0, 8'h11, 1);
    u_lsam_lin_node.send(1'b1, 8'h33, 3);
    u_lsam_lin_node.send(1'b1, 8'h5A, 1);
    u_lsam_lin_node.send(1'b0, 8'h77, 1);
    repeat (3) @(posedge clk);
    chk(rx_cnt - n, 32'h2, "matched traffic only");
    chk(32'(rx_byte_available), 32'h1, "byte available");
    rx_byte_taken <= 1'b1;
    @(posedge clk);
    rx_byte_taken <= 1'b0;
    @(posedge clk);
    chk(32'(rx_byte_available), 32'h0, "byte taken");
    u_lsam_lin_node.send(1'b1, 8'h5B, 1);
    u_lsam_lin_node.send(1'b0, 8'h12, 1);
    wr(IDX_CFG, 32'h0);
    u_lsam_lin_node.send(1'b0, 8'h13, 1);
    repeat (3) @(posedge clk);
    chk(rx_cnt - n, 32'h3, "compare off delivers");
    $display("test filter done");
  endtask

  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    rx_byte_taken = 1'b0;
    failures = 0;
    checks = 0;
    cyc = 0;
    rx_cnt = 0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_regs();
    t_slave();
    t_master();
    t_filter();
    finish_test();
  end
endmodule
`default_nettype wire
